//--- cppm_pkg.sv
// Purpose: Shared constants and types for the clock prescaler and power mode block
// Assumes: One oscillator clock; the watch clock arrives as a slow pin level
// Notes: Counts and codes are named once here and used by name elsewhere
package cppm_pkg;

    // ==========================================================
    // Prescaler widths and reset values
    localparam int SYS_PS_WIDTH = 13;
    localparam int W_PS_WIDTH = 5;
    localparam logic [12:0] SYS_PS_RESET = 13'h0000;
    localparam logic [4:0] W_PS_RESET = 5'h00;

    // ==========================================================
    // Watch clock figures
    localparam real WATCH_FREQ_KHZ = 32.768;
    localparam int WATCH_PRE_DIV = 4;
    localparam int WDIV_WIDTH = 3;
    localparam logic [2:0] WDIV_RESET = 3'h0;

    // ==========================================================
    // System clock division select codes and last divider counts
    localparam int OSC_DIV_WIDTH = 6;
    localparam logic [5:0] OSC_DIV_RESET = 6'h00;
    localparam logic [2:0] SYSDIV_1 = 3'h0;
    localparam logic [2:0] SYSDIV_8 = 3'h1;
    localparam logic [2:0] SYSDIV_16 = 3'h2;
    localparam logic [2:0] SYSDIV_32 = 3'h3;
    localparam logic [2:0] SYSDIV_64 = 3'h4;
    localparam logic [5:0] LAST_1 = 6'h00;
    localparam logic [5:0] LAST_8 = 6'h07;
    localparam logic [5:0] LAST_16 = 6'h0f;
    localparam logic [5:0] LAST_32 = 6'h1f;
    localparam logic [5:0] LAST_64 = 6'h3f;

    // ==========================================================
    // Subclock division select codes
    localparam logic [1:0] SUBDIV_2 = 2'h0;
    localparam logic [1:0] SUBDIV_4 = 2'h1;
    localparam logic [1:0] SUBDIV_8 = 2'h2;

    // ==========================================================
    // Interval timer mode register bit positions
    localparam int TMR_HI_POS = 3;
    localparam int TMR_LO_POS = 2;

    // ==========================================================
    // Peripheral count and operating modes
    localparam int NUM_MODULES = 8;

    typedef enum logic [2:0] {
        CPPM_ACTIVE,
        CPPM_SLEEP,
        CPPM_SUBACTIVE,
        CPPM_SUBSLEEP,
        CPPM_STANDBY
    } cppm_mode_type;

endpackage

//--- cppm_prescaler.sv
// Purpose: Free-running up-counter with one registered tap pulse per bit
// Assumes: advance is a one-cycle enable on the same clock
// Notes: Tap k pulses once every 2**(k+1) advances
`timescale 1ns/10ps
`default_nettype none
module cppm_prescaler #(
    parameter int WIDTH = 13
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic advance,
    output logic [WIDTH-1:0] count_ff,
    output logic [WIDTH-1:0] tap_ff
);

    // ==========================================================
    // Counter and taps
    logic [WIDTH-1:0] nxt_count;
    logic [WIDTH-1:0] nxt_tap;

    always_comb begin
        nxt_count = count_ff;
        if (clear) begin
            nxt_count = '0;
        end else if (advance) begin
            nxt_count = count_ff + 1'b1;
        end
    end

    generate
        for (genvar k = 0; k < WIDTH; k++) begin : g_tap
            always_comb begin
                nxt_tap[k] = advance && !clear && (&count_ff[k:0]);
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= '0;
            tap_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            tap_ff <= nxt_tap;
        end
    end

endmodule
`default_nettype wire

//--- cppm_clock_control.sv
// Purpose: System and watch prescalers and mode-driven clock enables
// Assumes: clock is the oscillator clock; the watch clock is a pin level
// Notes: Every divided clock leaves as a one-cycle enable pulse
// Overview of operation
// - System prescaler is a 13-bit counter advancing once per system clock.
// - System prescaler clears on reset and counts after reset release.
// - Standby, subactive and subsleep stop system clock and hold prescaler at zero.
// - System prescaler count has no processor read or write path.
// - System taps run from clock over 2 to over 8192, shared by peripherals.
// - In active and sleep, system clock is oscillator divided by the select field.
// - Watch prescaler is a 5-bit counter fed by watch clock over 4.
// - Watch clock over 4 enable, the watch prescaler input, drives the interval timer time base when selected, in standby only.
// - Watch prescaler clears on reset and counts after release.
// - Watch prescaler keeps counting in standby, subactive and subsleep.
// - Writing ones to both upper timer mode bits clears watch prescaler.
// - Subclock taps run from watch clock over 8 to over 128.
// - Active mode runs all on oscillator over 1, 8, 16, 32 or 64.
// - Subactive runs all on watch clock over 2, 4 or 8.
// - Sleep and subsleep stop processor; peripherals keep their clock.
// - Standby stops all except interval timer when time base selected.
// - Individual unused peripherals can be stopped one by one.
`timescale 1ns/10ps
`default_nettype none
module cppm_clock_control
    import cppm_pkg::*;
#(
    parameter int MODULES = cppm_pkg::NUM_MODULES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire cppm_pkg::cppm_mode_type mode,
    input wire logic [2:0] sysclk_div_select,
    input wire logic [1:0] sub_div_select,
    input wire logic watch_clk_pin,
    input wire logic tmr_mode_wr,
    input wire logic [3:0] tmr_mode_wdata,
    input wire logic clock_timebase_sel,
    input wire logic [MODULES-1:0] module_stop,
    output logic sys_clk_en,
    output logic sub_clk_en,
    output logic cpu_clk_en,
    output logic [MODULES-1:0] periph_clk_en,
    output logic timer_clk_en,
    output logic [cppm_pkg::SYS_PS_WIDTH-1:0] sys_taps,
    output logic [cppm_pkg::W_PS_WIDTH-1:0] watch_taps
);

    import cppm_pkg::*;

    // ==========================================================
    // Mode decode
    logic sys_run;
    logic sub_mode;
    logic cpu_mode;

    always_comb begin
        sys_run = (mode == CPPM_ACTIVE) || (mode == CPPM_SLEEP);
        sub_mode = (mode == CPPM_SUBACTIVE) || (mode == CPPM_SUBSLEEP);
        cpu_mode = (mode == CPPM_ACTIVE) || (mode == CPPM_SUBACTIVE);
    end

    // ==========================================================
    // Oscillator divider producing the system clock enable
    function automatic logic [5:0] div_last(input logic [2:0] sel);
        logic [5:0] last;
        last = LAST_1;
        if (sel == SYSDIV_8) begin
            last = LAST_8;
        end else if (sel == SYSDIV_16) begin
            last = LAST_16;
        end else if (sel == SYSDIV_32) begin
            last = LAST_32;
        end else if (sel == SYSDIV_64) begin
            last = LAST_64;
        end
        return last;
    endfunction

    logic [OSC_DIV_WIDTH-1:0] osc_div_ff;
    logic [OSC_DIV_WIDTH-1:0] nxt_osc_div;
    logic osc_wrap;

    always_comb begin
        osc_wrap = (osc_div_ff >= div_last(sysclk_div_select));
        nxt_osc_div = osc_div_ff + 1'b1;
        if (!sys_run || osc_wrap) begin
            nxt_osc_div = OSC_DIV_RESET;
        end
        sys_clk_en = sys_run && osc_wrap;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            osc_div_ff <= OSC_DIV_RESET;
        end else begin
            osc_div_ff <= nxt_osc_div;
        end
    end

    // ==========================================================
    // System prescaler; count stays internal with no access port
    logic [SYS_PS_WIDTH-1:0] sys_count;

    cppm_prescaler #(
        .WIDTH(SYS_PS_WIDTH)
    ) u_sys_ps (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(!sys_run),
        .advance(sys_clk_en),
        .count_ff(sys_count),
        .tap_ff(sys_taps)
    );

    // ==========================================================
    // Watch clock pin synchroniser and edge detection
    logic [2:0] wsync_ff;
    logic [2:0] nxt_wsync;
    logic wlevel_ff;
    logic nxt_wlevel;
    logic watch_rise;

    always_comb begin
        nxt_wsync = {wsync_ff[1:0], watch_clk_pin};
        nxt_wlevel = wlevel_ff;
        if (wsync_ff[1] == wsync_ff[2]) begin
            nxt_wlevel = wsync_ff[2];
        end
        watch_rise = nxt_wlevel && !wlevel_ff;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wsync_ff <= 3'h0;
            wlevel_ff <= 1'b0;
        end else begin
            wsync_ff <= nxt_wsync;
            wlevel_ff <= nxt_wlevel;
        end
    end

    // ==========================================================
    // Watch clock divider: subclock and watch-over-4 enables
    logic [WDIV_WIDTH-1:0] wdiv_ff;
    logic [WDIV_WIDTH-1:0] nxt_wdiv;
    logic wq_en;

    always_comb begin
        nxt_wdiv = wdiv_ff;
        if (watch_rise) begin
            nxt_wdiv = wdiv_ff + 1'b1;
        end
        wq_en = watch_rise && (&wdiv_ff[1:0]);
        sub_clk_en = watch_rise && wdiv_ff[0];
        if (sub_div_select == SUBDIV_4) begin
            sub_clk_en = watch_rise && (&wdiv_ff[1:0]);
        end else if (sub_div_select == SUBDIV_8) begin
            sub_clk_en = watch_rise && (&wdiv_ff);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wdiv_ff <= WDIV_RESET;
        end else begin
            wdiv_ff <= nxt_wdiv;
        end
    end

    // ==========================================================
    // Watch prescaler, cleared by the timer mode write
    logic [W_PS_WIDTH-1:0] w_count;
    logic tmr_clear;

    always_comb begin
        tmr_clear = tmr_mode_wr && tmr_mode_wdata[TMR_HI_POS]
            && tmr_mode_wdata[TMR_LO_POS];
    end

    cppm_prescaler #(
        .WIDTH(W_PS_WIDTH)
    ) u_w_ps (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(tmr_clear),
        .advance(wq_en),
        .count_ff(w_count),
        .tap_ff(watch_taps)
    );

    // ==========================================================
    // Processor, peripheral and timer enables
    logic periph_base;

    always_comb begin
        periph_base = 1'b0;
        cpu_clk_en = 1'b0;
        if (sys_run) begin
            periph_base = sys_clk_en;
        end else if (sub_mode) begin
            periph_base = sub_clk_en;
        end
        if (cpu_mode) begin
            cpu_clk_en = periph_base;
        end
        periph_clk_en = {MODULES{periph_base}} & ~module_stop;
        timer_clk_en = periph_base;
        if (mode == CPPM_STANDBY) begin
            timer_clk_en = clock_timebase_sel && wq_en;
        end
    end

    // ==========================================================
    // Checks
    sequence sys_gap8_s;
        (sys_run && sysclk_div_select == SYSDIV_8)[*8];
    endsequence

    property sys_div8_p;
        @(posedge clock) disable iff (sys_rst)
        (sys_clk_en && sysclk_div_select == SYSDIV_8) ##1 sys_gap8_s
            |-> sys_clk_en;
    endproperty

    sequence tmr_clr_s;
        tmr_mode_wr && tmr_mode_wdata[3:2] == 2'h3;
    endsequence

    sys_step_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !sys_rst && sys_clk_en && sys_count != 13'h1fff
            |=> sys_count == $past(sys_count) + 13'h0001)
        else $error("system prescaler did not advance");

    sys_hold_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sys_run && !sys_clk_en && $past(sys_run) |=> $stable(sys_count))
        else $error("system prescaler moved without enable");

    sys_start_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        $past(sys_rst) |-> sys_count <= 13'h0001)
        else $error("system prescaler not cleared by reset");

    sys_halt_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !sys_run |-> !sys_clk_en ##1 (sys_count == 13'h0000
            && sys_taps == 13'h0000))
        else $error("system prescaler runs in a stop mode");

    sys_div_a: assert property (sys_div8_p)
        else $error("system clock divide by 8 spacing wrong");

    sys_full_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sys_run && sysclk_div_select == SYSDIV_1 && $past(sys_run)
            |-> sys_clk_en)
        else $error("undivided system clock missing an edge");

    w_step_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        wq_en && !tmr_clear |=> w_count == $past(w_count) + 5'h01)
        else $error("watch prescaler did not advance");

    w_keep_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !wq_en && !tmr_clear |=> $stable(w_count))
        else $error("watch prescaler moved without enable");

    w_clear_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        tmr_clr_s |=> w_count == 5'h00 && watch_taps == 5'h00)
        else $error("timer mode write did not clear watch prescaler");

    w_wrap_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        wq_en && !tmr_clear && w_count == 5'h1f
            |=> w_count == 5'h00 && watch_taps == 5'h1f)
        else $error("watch prescaler wrap wrong");

    sys_wrap_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sys_clk_en && sys_count == 13'h1fff
            |=> sys_count == 13'h0000 && sys_taps == 13'h1fff)
        else $error("system prescaler wrap wrong");

    sub_sel_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sub_clk_en && sub_div_select == SUBDIV_8 |-> wdiv_ff == 3'h7)
        else $error("subclock divide by 8 phase wrong");

    cpu_stop_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !cpu_mode |-> !cpu_clk_en)
        else $error("processor clocked in a halt mode");

    sub_run_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sub_mode |-> periph_clk_en == ({MODULES{sub_clk_en}} & ~module_stop))
        else $error("peripherals not on subclock");

    standby_stop_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == CPPM_STANDBY |-> periph_clk_en == '0 && !cpu_clk_en
            && (timer_clk_en == (clock_timebase_sel && wq_en)))
        else $error("standby clock gating wrong");

    mod_stop_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (periph_clk_en & module_stop) == '0)
        else $error("stopped module still clocked");

    w_start_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        $past(sys_rst) |-> w_count <= 5'h01)
        else $error("watch prescaler not cleared by reset");

    sys_tap_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sys_clk_en && sys_count[0] |=> sys_taps[0])
        else $error("system tap over 2 missing");

    tap_idle_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !sys_rst && !sys_clk_en |=> sys_taps == 13'h0000)
        else $error("system tap without an advance");

    cpu_run_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == CPPM_ACTIVE |-> cpu_clk_en == sys_clk_en)
        else $error("processor not on system clock");

    sub_cpu_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == CPPM_SUBACTIVE |-> cpu_clk_en == sub_clk_en)
        else $error("processor not on subclock");

    sleep_run_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        mode == CPPM_SLEEP |-> periph_clk_en == ({MODULES{sys_clk_en}} & ~module_stop))
        else $error("peripherals not on system clock in sleep");

    sub_div2_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        sub_clk_en && sub_div_select == SUBDIV_2 |-> wdiv_ff[0])
        else $error("subclock divide by 2 phase wrong");

    w_tap_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        wq_en && !tmr_clear && w_count[0] |=> watch_taps[0])
        else $error("watch tap over 8 missing");

endmodule
`default_nettype wire

//--- cppm_periph_model.sv
// Purpose: Peripheral stand-in that counts the clock enables it is given
// Assumes: clk_en is a one-cycle enable on clock
// Notes: clear zeroes the count at the next edge
`timescale 1ns/10ps
`default_nettype none
module cppm_periph_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic clk_en,
    output logic [15:0] ticks_ff
);
    logic [15:0] nxt_ticks;
    always_comb begin
        nxt_ticks = ticks_ff;
        if (clear) begin
            nxt_ticks = 16'h0000;
        end else if (clk_en) begin
            nxt_ticks = ticks_ff + 16'h0001;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ticks_ff <= 16'h0000;
        end else begin
            ticks_ff <= nxt_ticks;
        end
    end
endmodule
`default_nettype wire

//--- clock_prescalers_power_modes_tb_top.sv
// Purpose: Self-checking bench for the clock prescaler and power mode block
// Assumes: Watch pin runs scaled to a 16-cycle period; ratios do not depend on it
// Notes: Gaps between enable pulses are measured, so phase does not matter
`timescale 1ns/10ps
`default_nettype none
module clock_prescalers_power_modes_tb_top;
    import cppm_pkg::*;
    typedef struct {cppm_mode_type m; logic [2:0] sd; logic [1:0] ud; logic ms; logic tb; int b; int e;} cppm_row_type;
    logic clock, sys_rst, watch_clk_pin, tmr_mode_wr, clock_timebase_sel, sys_clk_en, sub_clk_en, cpu_clk_en;
    logic timer_clk_en, pclr;
    cppm_mode_type mode;
    logic [2:0] sysclk_div_select;
    logic [1:0] sub_div_select;
    logic [3:0] tmr_mode_wdata, wph;
    logic [7:0] module_stop, periph_clk_en;
    logic [12:0] sys_taps;
    logic [4:0] watch_taps;
    logic [22:0] probe;
    logic [31:0] pticks;
    int num_errors = 0, n_tests = 0, g, wt_cnt;
    logic [3:0] wvals [3] = '{4'hc, 4'h4, 4'h8};
    // ==========================================================
    // Rows: mode, sys select, sub select, stop bit 0, time base, probe bit, gap
    cppm_row_type rows [26] = '{
        '{CPPM_ACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 0, 1},
        '{CPPM_ACTIVE, SYSDIV_8, SUBDIV_2, 0, 0, 0, 8},
        '{CPPM_ACTIVE, SYSDIV_16, SUBDIV_2, 0, 0, 0, 16},
        '{CPPM_ACTIVE, SYSDIV_32, SUBDIV_2, 0, 0, 0, 32},
        '{CPPM_ACTIVE, SYSDIV_64, SUBDIV_2, 0, 0, 0, 64},
        '{CPPM_ACTIVE, SYSDIV_8, SUBDIV_2, 0, 0, 2, 8},
        '{CPPM_ACTIVE, SYSDIV_16, SUBDIV_2, 0, 0, 4, 16},
        '{CPPM_SLEEP, SYSDIV_16, SUBDIV_2, 0, 0, 0, 16},
        '{CPPM_SLEEP, SYSDIV_16, SUBDIV_2, 0, 0, 2, 0},
        '{CPPM_SLEEP, SYSDIV_16, SUBDIV_2, 0, 0, 3, 16},
        '{CPPM_SUBACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 0, 0},
        '{CPPM_SUBACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 5, 0},
        '{CPPM_SUBACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 1, 32},
        '{CPPM_SUBACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 2, 32},
        '{CPPM_SUBACTIVE, SYSDIV_1, SUBDIV_4, 0, 0, 2, 64},
        '{CPPM_SUBACTIVE, SYSDIV_1, SUBDIV_8, 0, 0, 2, 128},
        '{CPPM_SUBSLEEP, SYSDIV_1, SUBDIV_2, 0, 0, 2, 0},
        '{CPPM_SUBSLEEP, SYSDIV_1, SUBDIV_2, 0, 0, 3, 32},
        '{CPPM_STANDBY, SYSDIV_1, SUBDIV_2, 0, 1, 3, 0},
        '{CPPM_STANDBY, SYSDIV_1, SUBDIV_2, 0, 1, 4, 64},
        '{CPPM_STANDBY, SYSDIV_1, SUBDIV_2, 0, 0, 4, 0},
        '{CPPM_STANDBY, SYSDIV_1, SUBDIV_2, 0, 0, 18, 128},
        '{CPPM_STANDBY, SYSDIV_1, SUBDIV_2, 0, 0, 22, 2048},
        '{CPPM_ACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 5, 2},
        '{CPPM_ACTIVE, SYSDIV_1, SUBDIV_2, 0, 0, 17, 8192},
        '{CPPM_ACTIVE, SYSDIV_8, SUBDIV_2, 1, 0, 3, 0}
    };
    assign probe = {watch_taps, sys_taps, timer_clk_en, periph_clk_en[0], cpu_clk_en, sub_clk_en, sys_clk_en};
    cppm_clock_control #(.MODULES(8)) i_cppm_clock_control (.clock(clock), .sys_rst(sys_rst), .mode(mode),
        .sysclk_div_select(sysclk_div_select), .sub_div_select(sub_div_select), .watch_clk_pin(watch_clk_pin),
        .tmr_mode_wr(tmr_mode_wr), .tmr_mode_wdata(tmr_mode_wdata), .clock_timebase_sel(clock_timebase_sel),
        .module_stop(module_stop), .sys_clk_en(sys_clk_en), .sub_clk_en(sub_clk_en), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .timer_clk_en(timer_clk_en), .sys_taps(sys_taps), .watch_taps(watch_taps));
    cppm_periph_model i_cppm_periph_model [1:0] (.clock(clock), .sys_rst(sys_rst), .clear(pclr),
        .clk_en(periph_clk_en[1:0]), .ticks_ff(pticks));
    // ==========================================================
    // Clock, scaled watch pin and counters
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        wph <= wph + 4'h1;
        if (wph == 4'h7 || wph == 4'hf) watch_clk_pin <= ~watch_clk_pin;
    end
    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic gap(input int b, input int e, output int gg);
        int lim, n;
        lim = (e == 0) ? 300 : 2 * e + 40;
        n = 0;
        gg = 0;
        while (probe[b] !== 1'b1 && n < lim) begin
            @(posedge clock);
            #1 n++;
        end
        if (n < lim) begin
            gg = 1;
            @(posedge clock);
            #1 while (probe[b] !== 1'b1 && gg < lim) begin
                @(posedge clock);
                #1 gg++;
            end
        end
    endtask
    task automatic results();
        $display("Tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #400000 num_errors++;
        results();
    end
    // ==========================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1; mode = CPPM_ACTIVE; sysclk_div_select = SYSDIV_1; sub_div_select = SUBDIV_2;
        watch_clk_pin = 1'b0; wph = 4'h0; tmr_mode_wr = 1'b0; tmr_mode_wdata = 4'h0;
        clock_timebase_sel = 1'b0; module_stop = 8'h00; pclr = 1'b0; wt_cnt = 0;
        repeat (9) @(posedge clock);
        #1 chk(sys_taps === 13'h0000 && watch_taps === 5'h00, "taps not clear in reset");
        @(posedge clock);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clock);
            mode <= rows[i].m; sysclk_div_select <= rows[i].sd; sub_div_select <= rows[i].ud;
            module_stop <= {7'h00, rows[i].ms}; clock_timebase_sel <= rows[i].tb;
            repeat (8) @(posedge clock);
            #1 gap(rows[i].b, rows[i].e, g);
            chk(g == rows[i].e, $sformatf("row %0d gap %0d", i, g));
        end
        // Stopped peripheral sees no enable, its neighbour one per 8 cycles
        @(posedge clock) pclr <= 1'b1;
        @(posedge clock) pclr <= 1'b0;
        repeat (200) @(posedge clock);
        #1 chk(pticks === {16'h0019, 16'h0000}, "peripheral counts");
        // Timer writes every 32 cycles: only both upper bits clear
        @(posedge clock) mode <= CPPM_STANDBY;
        // Taps are counted over 640 cycles, exactly ten watch-over-4 ticks
        foreach (wvals[v]) begin
            wt_cnt = 0;
            for (int k = 0; k < 672; k++) begin
                @(posedge clock);
                tmr_mode_wr <= (k % 32 == 0);
                tmr_mode_wdata <= wvals[v];
                #1 if (k >= 32 && watch_taps[0] === 1'b1) wt_cnt++;
            end
            chk(wt_cnt == ((wvals[v] == 4'hc) ? 0 : 5), $sformatf("watch taps %0d", wt_cnt));
        end
        // Reset in mid-run clears both prescalers, counting resumes after
        @(posedge clock) begin
            mode <= CPPM_ACTIVE;
            sysclk_div_select <= SYSDIV_1;
            sys_rst <= 1'b1;
        end
        @(posedge clock);
        #1 chk(sys_taps === 13'h0000 && watch_taps === 5'h00, "taps not clear");
        repeat (9) @(posedge clock);
        sys_rst <= 1'b0;
        #1 gap(5, 2, g);
        chk(g == 2, "no count after reset");
        results();
    end
endmodule
`default_nettype wire
